// ===== src/tdm_test_pkg.sv
// Purpose: Shared constants for the per-stream test and coding block.
// Assumes: 14-bit word address, 16-bit data, 32 streams.
// Notes: Addresses are word addresses on the microprocessor port.
package tdm_test_pkg;
    // ==========================================================
    // Sizes
    localparam int NUM_STREAMS = 32;
    localparam int ADDR_W = 14;
    localparam int DATA_W = 16;
    // ==========================================================
    // Register addresses
    localparam logic [13:0] GLOBAL_MODE_ADDR = 14'h0001;
    localparam logic [13:0] QUAD_FORCE_BASE = 14'h0120;
    localparam logic [13:0] START_CHAN_BASE = 14'h0300;
    localparam logic [13:0] CHAN_LEN_BASE = 14'h0320;
    localparam logic [13:0] RX_CTRL_BASE = 14'h0340;
    localparam logic [13:0] ERR_COUNT_BASE = 14'h0360;
    // ==========================================================
    // Field positions
    localparam int RX_ALL_EN_BIT = 5;
    localparam int TX_ALL_EN_BIT = 4;
    localparam int CNT_CLEAR_BIT = 1;
    localparam int RX_EN_BIT = 0;
    localparam int START_W = 8;
    localparam int LEN_W = 9;
    localparam int QUAD_W = 12;
    localparam int QCTRL_W = 3;
    localparam int VOICE_DATA_BIT = 4;
    localparam int MSG_MODE_BIT = 0;
    localparam logic [1:0] PATTERN_CODE = 2'h2;
    // ==========================================================
    // Reset values and constants
    localparam logic [15:0] GLOBAL_MODE_RESET = 16'h0000;
    localparam logic [15:0] ERR_COUNT_MAX = 16'hFFFF;
    localparam logic [14:0] PRBS_SEED = 15'h7FFF;
    localparam logic [1:0] LOCK_FILL = 2'h2;
    // ==========================================================
    // Law masks: voice A, mu, A plain, mu plain; data none, even, odd, all
    localparam logic [7:0] MASK_A = 8'h55;
    localparam logic [7:0] MASK_MU = 8'hFF;
    localparam logic [7:0] MASK_A_PLAIN = 8'h00;
    localparam logic [7:0] MASK_MU_PLAIN = 8'h80;
    localparam logic [7:0] MASK_NONE = 8'h00;
    localparam logic [7:0] MASK_EVEN = 8'h55;
    localparam logic [7:0] MASK_ODD = 8'hAA;
    localparam logic [7:0] MASK_ALL = 8'hFF;
endpackage : tdm_test_pkg

// ===== src/tdm_channel_test_and_coding.sv
// Purpose: Pattern test, code-law translation and quadrant bit forcing.
// Assumes: Channel slots arrive one per cycle on clk_i from the switch core.
// Notes: Register port is a synchronous word port with one-cycle ack.
// Summary of operation
// - 32 pattern transmitters and 32 receivers
// - Pattern is 2^15-1 pseudorandom sequence
// - Pattern may start anywhere, up to frame
// - Mode bits 5/4 enable receivers/transmitters; off
// - Control bit1 clears count, bit0 enables
// - Start register picks first compared channel
// - Length register gives compared channel count
// - Sixteen-bit error count saturates at FFFF
// - Law translation per output channel, bypassed in pattern mode
// - Upper word: voice/data, input law, output law
// - Law code meanings for voice and data
// - Variant laws leave listed bits uninverted
// - Data codes flip even, odd or all bits
// - Translate differing laws; equal laws pass unchanged
// - Frame splits into four equal quadrants
// - Quadrant controls at bits 11-9 down to 2-0
// - 0xx none; 10x force LSB; 11x MSB
`timescale 1ns/1ps
module tdm_channel_test_and_coding (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic cs_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [tdm_test_pkg::ADDR_W-1:0] addr_i,
    input wire logic [tdm_test_pkg::DATA_W-1:0] wdata_i,
    output logic [tdm_test_pkg::DATA_W-1:0] rdata_o,
    output logic ack_o,
    input wire logic rx_valid_i,
    input wire logic [4:0] rx_stream_i,
    input wire logic [7:0] rx_chan_i,
    input wire logic [1:0] rx_rate_i,
    input wire logic [7:0] rx_data_i,
    output logic rx_valid_o,
    output logic [7:0] rx_data_o,
    input wire logic tx_valid_i,
    input wire logic [4:0] tx_stream_i,
    input wire logic [2:0] tx_lower_i,
    input wire logic [4:0] tx_upper_i,
    input wire logic [7:0] tx_data_i,
    output logic tx_ready_o,
    output logic tx_valid_o,
    output logic [7:0] tx_data_o,
    input wire logic tx_ready_i
);
    import tdm_test_pkg::*;

    typedef struct packed {
        logic rx_all_en;
        logic tx_all_en;
        logic [31:0] rx_en;
        logic [31:0][7:0] start;
        logic [31:0][8:0] len;
        logic [31:0][11:0] quad;
        logic [31:0][15:0] errcnt;
        logic [31:0][14:0] rx_lfsr;
        logic [31:0][1:0] rx_fill;
        logic [31:0][14:0] tx_lfsr;
        logic [15:0] rdata;
        logic ack;
        logic rxv;
        logic [7:0] rxd;
        logic stgv;
        logic [7:0] stgd;
        logic [1:0] bufv;
        logic [1:0][7:0] bufd;
        logic ready;
    } state_type;

    state_type s_q, s_d;
    logic [2:0] qc_now;

    // ==========================================================
    // Helper functions
    function automatic logic [22:0] prbs8(input logic [14:0] st);
        logic [14:0] s;
        logic [7:0] b;
        s = (st == '0) ? PRBS_SEED : st;
        for (int i = 7; i >= 0; i--) begin
            b[i] = s[14] ^ s[13];
            s = {s[13:0], b[i]};
        end
        return {b, s};
    endfunction : prbs8

    function automatic logic [3:0] msb14(input logic [13:0] v);
        logic [3:0] p;
        p = '0;
        for (int i = 0; i < 14; i++) begin
            p = v[i] ? 4'(i) : p;
        end
        return p;
    endfunction : msb14

    function automatic logic [7:0] law_mask(input logic voice, input logic [1:0] c);
        logic [7:0] m;
        unique case ({voice, c})
            3'b100: m = MASK_A;
            3'b101: m = MASK_MU;
            3'b110: m = MASK_A_PLAIN;
            3'b111: m = MASK_MU_PLAIN;
            3'b000: m = MASK_NONE;
            3'b001: m = MASK_EVEN;
            3'b010: m = MASK_ODD;
            3'b011: m = MASK_ALL;
        endcase
        return m;
    endfunction : law_mask

    function automatic logic [7:0] law_xlate(input logic [4:0] up, input logic [7:0] d);
        logic voice;
        logic [7:0] raw;
        logic [13:0] lin;
        logic [13:0] v;
        logic [2:0] sg;
        logic [3:0] p;
        voice = !up[VOICE_DATA_BIT];
        raw = d ^ law_mask(voice, up[3:2]);
        sg = raw[6:4];
        if (up[3:2] == up[1:0]) begin
            return d;
        end
        if (!voice || up[2] == up[0]) begin
            return raw ^ law_mask(voice, up[1:0]);
        end
        if (!up[2]) begin
            // A-law in, mu-law out
            lin = (sg == 3'h0) ? {8'h00, raw[3:0], 2'h2} : ({8'h00, 1'b1, raw[3:0], 1'b1} << sg);
            v = lin + 14'h0021;
            if (v > 14'h1FFF) begin
                v = 14'h1FFF;
            end
            p = msb14(v) - 4'h5;
            v = v >> (p + 4'h1);
            raw = {~raw[7], p[2:0], v[3:0]};
        end else begin
            // mu-law in, A-law out
            lin = ({8'h00, 1'b1, raw[3:0], 1'b1} << sg) - 14'h0021;
            v = lin >> 1;
            if (v < 14'h0020) begin
                raw = {~raw[7], 3'h0, v[4:1]};
            end else begin
                p = msb14(v) - 4'h4;
                v = v >> p;
                raw = {~raw[7], p[2:0], v[3:0]};
            end
        end
        return raw ^ law_mask(1'b1, up[1:0]);
    endfunction : law_xlate

    function automatic logic [1:0] quadrant(input logic [7:0] ch, input logic [1:0] rate);
        return ch[3 + rate +: 2];
    endfunction : quadrant

    assign qc_now = s_q.quad[rx_stream_i][3 * quadrant(rx_chan_i, rx_rate_i) +: QCTRL_W];

    // ==========================================================
    // Next state
    always_comb begin
        logic [4:0] idx;
        logic [7:0] fd;
        logic [8:0] ch9;
        logic [8:0] lim;
        logic [22:0] pr;
        logic [16:0] sum;
        logic pop;
        logic push;
        logic acc;
        s_d = s_q;
        idx = addr_i[4:0];
        fd = rx_data_i;
        ch9 = {1'b0, rx_chan_i};
        lim = '0;
        pr = '0;
        sum = '0;
        s_d.ack = 1'b0;
        // Register port
        if (cs_i && (wr_i || rd_i)) begin
            s_d.ack = 1'b1;
            s_d.rdata = '0;
            if (wr_i) begin
                if (addr_i == GLOBAL_MODE_ADDR) begin
                    s_d.rx_all_en = wdata_i[RX_ALL_EN_BIT];
                    s_d.tx_all_en = wdata_i[TX_ALL_EN_BIT];
                end
                if (addr_i[13:5] == QUAD_FORCE_BASE[13:5]) begin
                    s_d.quad[idx] = wdata_i[QUAD_W-1:0];
                end
                if (addr_i[13:5] == START_CHAN_BASE[13:5]) begin
                    s_d.start[idx] = wdata_i[START_W-1:0];
                end
                if (addr_i[13:5] == CHAN_LEN_BASE[13:5]) begin
                    s_d.len[idx] = wdata_i[LEN_W-1:0];
                end
                if (addr_i[13:5] == RX_CTRL_BASE[13:5]) begin
                    s_d.rx_en[idx] = wdata_i[RX_EN_BIT];
                    if (wdata_i[CNT_CLEAR_BIT]) begin
                        s_d.errcnt[idx] = '0;
                    end
                end
            end else begin
                if (addr_i == GLOBAL_MODE_ADDR) begin
                    s_d.rdata[RX_ALL_EN_BIT] = s_q.rx_all_en;
                    s_d.rdata[TX_ALL_EN_BIT] = s_q.tx_all_en;
                end
                if (addr_i[13:5] == QUAD_FORCE_BASE[13:5]) begin
                    s_d.rdata[QUAD_W-1:0] = s_q.quad[idx];
                end
                if (addr_i[13:5] == START_CHAN_BASE[13:5]) begin
                    s_d.rdata[START_W-1:0] = s_q.start[idx];
                end
                if (addr_i[13:5] == CHAN_LEN_BASE[13:5]) begin
                    s_d.rdata[LEN_W-1:0] = s_q.len[idx];
                end
                if (addr_i[13:5] == RX_CTRL_BASE[13:5]) begin
                    s_d.rdata[RX_EN_BIT] = s_q.rx_en[idx];
                end
                if (addr_i[13:5] == ERR_COUNT_BASE[13:5]) begin
                    s_d.rdata = s_q.errcnt[idx];
                end
            end
        end
        // Receive slot: quadrant forcing and pattern checking
        s_d.rxv = rx_valid_i;
        if (rx_valid_i) begin
            if (qc_now[2] && qc_now[1]) begin
                fd[7] = qc_now[0];
            end else if (qc_now[2]) begin
                fd[0] = qc_now[0];
            end
            s_d.rxd = fd;
            lim = {1'b0, s_q.start[rx_stream_i]} + s_q.len[rx_stream_i];
            if (s_q.rx_all_en && s_q.rx_en[rx_stream_i] &&
                ch9 >= {1'b0, s_q.start[rx_stream_i]} && ch9 < lim) begin
                pr = prbs8(s_q.rx_lfsr[rx_stream_i]);
                if (s_q.rx_fill[rx_stream_i] != LOCK_FILL) begin
                    // Load received bits until the register is full
                    s_d.rx_lfsr[rx_stream_i] = {s_q.rx_lfsr[rx_stream_i][6:0], rx_data_i};
                    s_d.rx_fill[rx_stream_i] = s_q.rx_fill[rx_stream_i] + 2'h1;
                end else begin
                    s_d.rx_lfsr[rx_stream_i] = pr[14:0];
                    sum = {1'b0, s_d.errcnt[rx_stream_i]} + 17'($countones(pr[22:15] ^ rx_data_i));
                    s_d.errcnt[rx_stream_i] = sum[16] ? ERR_COUNT_MAX : sum[15:0];
                end
            end
        end
        for (int i = 0; i < NUM_STREAMS; i++) begin
            if (!s_q.rx_all_en || !s_q.rx_en[i]) begin
                s_d.rx_fill[i] = '0;
            end
        end
        // Transmit slot: stage, then two-entry buffer
        pop = s_q.bufv[0] && tx_ready_i;
        if (pop) begin
            s_d.bufv = {1'b0, s_q.bufv[1]};
            s_d.bufd[0] = s_q.bufd[1];
        end
        push = s_q.stgv && !(s_d.bufv == 2'h3);
        if (push) begin
            if (s_d.bufv[0]) begin
                s_d.bufv[1] = 1'b1;
                s_d.bufd[1] = s_q.stgd;
            end else begin
                s_d.bufv[0] = 1'b1;
                s_d.bufd[0] = s_q.stgd;
            end
        end
        acc = tx_valid_i && s_q.ready;
        s_d.stgv = (s_q.stgv && !push) || acc;
        if (acc) begin
            if (s_q.tx_all_en && tx_lower_i[MSG_MODE_BIT] && tx_lower_i[2:1] == PATTERN_CODE) begin
                pr = prbs8(s_q.tx_lfsr[tx_stream_i]);
                s_d.tx_lfsr[tx_stream_i] = pr[14:0];
                s_d.stgd = pr[22:15];
            end else begin
                s_d.stgd = law_xlate(tx_upper_i, tx_data_i);
            end
        end
        s_d.ready = !s_d.stgv || (s_d.bufv != 2'h3);
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata_o = s_q.rdata;
    assign ack_o = s_q.ack;
    assign rx_valid_o = s_q.rxv;
    assign rx_data_o = s_q.rxd;
    assign tx_ready_o = s_q.ready;
    assign tx_valid_o = s_q.bufv[0];
    assign tx_data_o = s_q.bufd[0];

    // ==========================================================
    // Assertions
    sequence clr_write_s;
        cs_i && wr_i && addr_i[13:5] == RX_CTRL_BASE[13:5] && wdata_i[CNT_CLEAR_BIT];
    endsequence

    ack_answer_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        cs_i && (wr_i || rd_i) |=> ack_o) else $error("ack missing");
    mode_reset_a: assert property (@(posedge clk_i)
        !resetn_i |=> !s_q.rx_all_en && !s_q.tx_all_en) else $error("enables not off");
    count_sat_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        s_q.errcnt[rx_stream_i] == ERR_COUNT_MAX && !(cs_i && wr_i)
        |=> s_q.errcnt[$past(rx_stream_i)] == ERR_COUNT_MAX) else $error("count wrapped");
    count_clear_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        clr_write_s |=> s_q.errcnt[$past(addr_i[4:0])] <= 16'h0008) else $error("clear lost");
    rx_idle_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !s_q.rx_all_en && !(cs_i && wr_i) |=> $stable(s_q.errcnt))
        else $error("count while off");
    quad_force_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        rx_valid_i && qc_now[2]
        |=> ($past(qc_now[1]) ? rx_data_o[7] : rx_data_o[0]) == $past(qc_now[0]))
        else $error("quadrant bit not forced");
    data_law_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        tx_valid_i && tx_ready_o && !s_q.tx_all_en && tx_upper_i[4]
        |=> s_q.stgd == ($past(tx_data_i) ^ law_mask(1'b0, $past(tx_upper_i[3:2]))
        ^ law_mask(1'b0, $past(tx_upper_i[1:0])))) else $error("data law wrong");
    same_law_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        tx_valid_i && tx_ready_o && !s_q.tx_all_en && tx_upper_i[3:2] == tx_upper_i[1:0]
        |=> s_q.stgd == $past(tx_data_i)) else $error("byte altered");
    buf_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o)) else $error("word lost");
endmodule : tdm_channel_test_and_coding

// ===== tb/tdm_sink_model.sv
// Purpose: Downstream sink that paces tx_ready_i with pseudorandom stalls.
// Assumes: Ready changes only just after a clock edge.
// Notes: hold_i forces a long stall so the block's buffer fills up.
`timescale 1ns/1ps
module tdm_sink_model (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic hold_i,
    output logic ready_o
);
    logic [7:0] pace_q;
    // ==========================================================
    // Stall pattern
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            pace_q <= 8'hA5;
            ready_o <= 1'b0;
        end else begin
            pace_q <= {pace_q[6:0], pace_q[7] ^ pace_q[5] ^ pace_q[4] ^ pace_q[3]};
            ready_o <= !hold_i && (pace_q[1:0] != 2'h0);
        end
    end
endmodule : tdm_sink_model

// ===== tb/testbench.sv
// Purpose: Self-checking bench for the test and coding block.
// Assumes: Expected values come from the register map and coding tables.
// Notes: Captured pattern bytes are looped back into the receiver.
`timescale 1ns/1ps
module testbench;
    import tdm_test_pkg::*;
    localparam int FRAME_CYC = 15625;
    localparam int LIMIT = 70000;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic cs_i = 1'b0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [13:0] addr_i = 14'h0000;
    logic [15:0] wdata_i = 16'h0000;
    logic [15:0] rdata_o;
    logic ack_o;
    logic rx_valid_i = 1'b0;
    logic [4:0] rx_stream_i = 5'h00;
    logic [7:0] rx_chan_i = 8'h00;
    logic [1:0] rx_rate_i = 2'h0;
    logic [7:0] rx_data_i = 8'h00;
    logic rx_valid_o;
    logic [7:0] rx_data_o;
    logic tx_valid_i = 1'b0;
    logic [4:0] tx_stream_i = 5'h01;
    logic [2:0] tx_lower_i = 3'h0;
    logic [4:0] tx_upper_i = 5'h00;
    logic [7:0] tx_data_i = 8'h00;
    logic tx_ready_o;
    logic tx_valid_o;
    logic [7:0] tx_data_o;
    logic tx_ready_i;
    logic sink_hold = 1'b0;
    logic [16:0] regq[$];
    logic [7:0] rxq[$];
    logic [7:0] txq[$];
    logic [7:0] cap[$];
    logic [16:0] rege;
    logic [7:0] ex;
    logic [7:0] exo;
    logic [31:0] rnd;
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;
    int qd;
    logic [4:0] law_up [12] = '{5'h10, 5'h11, 5'h12, 5'h13, 5'h16, 5'h1F,
        5'h19, 5'h02, 5'h08, 5'h07, 5'h05, 5'h0F};
    logic [7:0] law_x [12] = '{8'h00, 8'h55, 8'hAA, 8'hFF, 8'hFF, 8'h00,
        8'hFF, 8'h55, 8'h55, 8'h7F, 8'h00, 8'h00};

    always #4 clk_i = ~clk_i;

    tdm_channel_test_and_coding uut (.clk_i(clk_i), .resetn_i(resetn_i), .cs_i(cs_i),
        .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
        .ack_o(ack_o), .rx_valid_i(rx_valid_i), .rx_stream_i(rx_stream_i),
        .rx_chan_i(rx_chan_i), .rx_rate_i(rx_rate_i), .rx_data_i(rx_data_i),
        .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o), .tx_valid_i(tx_valid_i),
        .tx_stream_i(tx_stream_i), .tx_lower_i(tx_lower_i), .tx_upper_i(tx_upper_i),
        .tx_data_i(tx_data_i), .tx_ready_o(tx_ready_o), .tx_valid_o(tx_valid_o),
        .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i));

    tdm_sink_model sink (.clk_i(clk_i), .resetn_i(resetn_i), .hold_i(sink_hold),
        .ready_o(tx_ready_i));

    // ==========================================================
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    function automatic logic bit_of(input int n);
        return cap[n / 8][7 - (n % 8)];
    endfunction : bit_of

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results

    // Write when w is set, else read and expect d
    task automatic reg_access(input logic w, input logic [13:0] a, input logic [15:0] d);
        @(posedge clk_i);
        cs_i <= 1'b1;
        wr_i <= w;
        rd_i <= !w;
        addr_i <= a;
        wdata_i <= d;
        regq.push_back({!w, d});
        @(posedge clk_i);
        cs_i <= 1'b0;
    endtask : reg_access

    // Called at a clock edge; returns one edge later
    task automatic rx(input logic [4:0] s, input logic [7:0] c, input logic [1:0] r,
                      input logic [7:0] d, input logic [7:0] e);
        rx_valid_i <= 1'b1;
        rx_stream_i <= s;
        rx_chan_i <= c;
        rx_rate_i <= r;
        rx_data_i <= d;
        rxq.push_back(e);
        @(posedge clk_i);
    endtask : rx

    // Called at a clock edge; returns at the edge that takes the slot
    task automatic tx(input logic [2:0] lo, input logic [4:0] up, input logic [7:0] d,
                      input logic note, input logic [7:0] e);
        tx_valid_i <= 1'b1;
        tx_lower_i <= lo;
        tx_upper_i <= up;
        tx_data_i <= d;
        if (note) txq.push_back(e);
        do @(posedge clk_i); while (tx_ready_o !== 1'b1);
    endtask : tx

    // ==========================================================
    // Output watcher
    always @(posedge clk_i) begin
        cycles++;
        if (cycles > LIMIT) begin
            bad_count++;
            results();
        end
        if (ack_o === 1'b1) begin
            rege = (regq.size() > 0) ? regq.pop_front() : 17'h1FFFF;
            if (rege[16]) chk(rdata_o, rege[15:0]);
        end
        if (rx_valid_o === 1'b1) begin
            exo = (rxq.size() > 0) ? rxq.pop_front() : 8'hXX;
            chk({8'h00, rx_data_o}, {8'h00, exo});
        end
        if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1) begin
            if (txq.size() > 0) chk({8'h00, tx_data_o}, {8'h00, txq.pop_front()});
            else cap.push_back(tx_data_o);
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        rnd = 32'h0001_3EAF;
        repeat (3) @(posedge clk_i);
        resetn_i <= 1'b1;
        reg_access(1'b0, GLOBAL_MODE_ADDR, GLOBAL_MODE_RESET);
        reg_access(1'b0, 14'h0400, 16'h0000);
        reg_access(1'b1, START_CHAN_BASE + 14'h0002, 16'hFFFF);
        reg_access(1'b0, START_CHAN_BASE + 14'h0002, 16'h00FF);
        reg_access(1'b1, CHAN_LEN_BASE + 14'h0002, 16'hFFFF);
        reg_access(1'b0, CHAN_LEN_BASE + 14'h0002, 16'h01FF);
        reg_access(1'b1, QUAD_FORCE_BASE + 14'h0002, 16'hFFFF);
        reg_access(1'b0, QUAD_FORCE_BASE + 14'h0002, 16'h0FFF);
        reg_access(1'b1, ERR_COUNT_BASE + 14'h0002, 16'hFFFF);
        reg_access(1'b0, ERR_COUNT_BASE + 14'h0002, 16'h0000);
        @(posedge clk_i);
        tx(3'h5, 5'h10, 8'h3C, 1'b1, 8'h3C);
        foreach (law_up[i]) begin
            rnd = lfsr(rnd);
            tx(3'h0, law_up[i], rnd[7:0], 1'b1, rnd[7:0] ^ law_x[i]);
        end
        tx_valid_i <= 1'b0;
        repeat (20) @(posedge clk_i);
        reg_access(1'b1, GLOBAL_MODE_ADDR, 16'h0030);
        reg_access(1'b0, GLOBAL_MODE_ADDR, 16'h0030);
        @(posedge clk_i);
        tx_stream_i <= 5'h05;
        repeat (8) tx(3'h5, 5'h10, 8'h00, 1'b0, 8'h00);
        tx_valid_i <= 1'b0;
        repeat (20) @(posedge clk_i);
        chk(16'(cap.size()), 16'h0008);
        for (int n = 15; n < 64; n++) chk({15'h0, bit_of(n)}, {15'h0, bit_of(n - 14) ^ bit_of(n - 15)});
        sink_hold <= 1'b1;
        fork
            for (int i = 0; i < 6; i++) tx(3'h0, 5'h10, 8'hA0 + 8'(i), 1'b1, 8'hA0 + 8'(i));
            begin
                repeat (20) @(posedge clk_i);
                chk({15'h0, tx_ready_o}, 16'h0000);
                sink_hold <= 1'b0;
            end
        join
        tx_valid_i <= 1'b0;
        reg_access(1'b1, QUAD_FORCE_BASE + 14'h0003, 16'h0FAC);
        reg_access(1'b1, QUAD_FORCE_BASE + 14'h0004, 16'h06DB);
        @(posedge clk_i);
        for (int r = 0; r < 4; r++) begin
            for (int c = 0; c < (32 << r); c++) begin
                rnd = lfsr(rnd);
                qd = c / (8 << r);
                ex = rnd[7:0];
                if (qd < 2) ex[0] = qd[0];
                else ex[7] = qd[0];
                rx(5'h03, 8'(c), 2'(r), rnd[7:0], ex);
                rx(5'h04, 8'(c), 2'(r), rnd[15:8], rnd[15:8]);
            end
        end
        rx_valid_i <= 1'b0;
        reg_access(1'b1, START_CHAN_BASE + 14'h0005, 16'h0010);
        reg_access(1'b1, CHAN_LEN_BASE + 14'h0005, 16'h0008);
        repeat (2 * FRAME_CYC) @(posedge clk_i);
        reg_access(1'b1, RX_CTRL_BASE + 14'h0005, 16'h0001);
        @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            ex = cap[i] ^ ((i == 6) ? 8'h13 : 8'h00);
            rx(5'h05, 8'h10 + 8'(i), 2'h3, ex, ex);
        end
        rx(5'h05, 8'h28, 2'h3, 8'h00, 8'h00);
        rx_valid_i <= 1'b0;
        reg_access(1'b0, ERR_COUNT_BASE + 14'h0005, 16'h0003);
        @(posedge clk_i);
        for (int i = 0; i < 20000; i++) begin
            rnd = lfsr(rnd);
            rx(5'h05, 8'h10 + 8'(i % 8), 2'h3, rnd[7:0], rnd[7:0]);
        end
        rx_valid_i <= 1'b0;
        reg_access(1'b0, ERR_COUNT_BASE + 14'h0005, ERR_COUNT_MAX);
        reg_access(1'b1, RX_CTRL_BASE + 14'h0005, 16'h0003);
        reg_access(1'b0, ERR_COUNT_BASE + 14'h0005, 16'h0000);
        for (int k = 0; k < 2; k++) begin
            reg_access(1'b1, GLOBAL_MODE_ADDR, (k == 0) ? 16'h0010 : 16'h0030);
            reg_access(1'b1, RX_CTRL_BASE + 14'h0005, (k == 0) ? 16'h0001 : 16'h0000);
            @(posedge clk_i);
            for (int i = 0; i < 16; i++) begin
                rnd = lfsr(rnd);
                rx(5'h05, 8'h10 + 8'(i % 8), 2'h3, rnd[7:0], rnd[7:0]);
            end
            rx_valid_i <= 1'b0;
            reg_access(1'b0, ERR_COUNT_BASE + 14'h0005, 16'h0000);
        end
        repeat (10) @(posedge clk_i);
        results();
    end
endmodule : testbench
